// ### tcs_pkg.sv
// Package: register map, codes and reset values of the command and status map
package tcs_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_ARG_ONE = 8'h0e;
   localparam logic [7:0] OFS_ARG_ZERO = 8'h0f;
   localparam logic [7:0] OFS_COMMAND_CODE = 8'h10;
   localparam logic [7:0] OFS_LAST_COMMAND_ECHO = 8'h11;
   localparam logic [7:0] OFS_FIRMWARE_MINOR_REV = 8'h12;
   localparam logic [7:0] OFS_FIRMWARE_PATCH_REV = 8'h13;
   localparam logic [7:0] OFS_OPERATION_STATUS = 8'h1d;
   localparam logic [7:0] OFS_RESULT_AREA_TAG = 8'h1e;
   localparam logic [7:0] OFS_MAP_UPDATE_TAG = 8'h1f;
   localparam logic [7:0] OFS_RESULT_FIRST = 8'h20;
   localparam logic [7:0] OFS_RESULT_LAST = 8'h9f;
   // ----------------------------------------
   // Command codes and fields
   // ----------------------------------------
   localparam logic [7:0] CMD_ADDR_CHANGE = 8'h49;
   localparam logic [7:0] CMD_HIST_FIRST = 8'h80;
   localparam logic [7:0] CMD_HIST_LAST = 8'h93;
   localparam logic [7:0] CMD_STOP = 8'hff;
   localparam int CONV_MSB = 4;
   localparam int CONV_LSB = 2;
   localparam int QUART_MSB = 1;
   localparam logic [2:0] CONV_LAST = 3'h4;
   localparam logic [1:0] QUART_LAST = 2'h3;
   localparam logic [2:0] HIST_TAG_TOP = 3'h4;
   // ----------------------------------------
   // Status and content tags
   // ----------------------------------------
   localparam logic [7:0] STATUS_OK = 8'h00;
   localparam logic [7:0] STATUS_ERR_FIRST = 8'h10;
   localparam logic [7:0] STATUS_ADDR_REFUSED = 8'h10;
   localparam logic [7:0] TAG_CALIB = 8'h0a;
   localparam logic [7:0] TAG_SERIAL = 8'h47;
   localparam logic [7:0] TAG_RESULTS = 8'h55;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [6:0] RST_BUS_ADDR = 7'h10;
   localparam logic [2:0] RST_SYNC = 3'h0;

   typedef enum logic [1:0] {
      TCS_IDLE = 2'b00,
      TCS_HIST = 2'b01,
      TCS_STOPPING = 2'b11
   } tcs_mode_t;
endpackage

// ### tcs_command_status_map.sv
// Command interpreter and status registers of the distance sensor host map
`timescale 1ns/1ps
// Notes on behaviour
// - Address change applies the new address only if masked pin levels equal the expected levels.
// - Codes 80h to 93h load one quarter of one converter histogram, converter in bits 4:2.
// - At the end of a quarter read the result area, content tag and transaction ID are refreshed.
// - After the last quarter of a converter the next converter follows automatically.
// - Stop returns the device to idle as soon as possible and ends continuous measurement.
// - Stop waits until the state being processed has finished before taking effect.
// - The echo register shows the last command executed, or the running one in continuous mode.
// - Status 00h to 0Fh means success and 10h to FFh means an error.
// - The content tag reads 0Ah calibration, 47h serial number, 55h measurement results.
// - Tags 80h to 93h mean raw histogram, four times converter plus quarter, 64 bins each.
// - The transaction ID changes with every update of the register map; here it stays unchanged when an address change updates the status.
module tcs_command_status_map #(
   parameter logic [7:0] FW_MINOR_REV = 8'h01, // Arbitrary value
   parameter logic [7:0] FW_PATCH_REV = 8'h02, // Arbitrary value
   parameter int CONV_COUNT = 5
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_rd_end,
   output logic [7:0] reg_rdata,
   input wire logic [7:0] res_rdata,
   output logic [6:0] res_index,
   input wire logic general_pin_zero,
   input wire logic general_pin_one,
   input wire logic stage_done,
   input wire logic area_load,
   input wire logic [7:0] area_tag,
   output logic [6:0] bus_addr,
   output logic [2:0] res_conv,
   output logic [1:0] res_quart,
   output logic res_load,
   output logic cmd_issue,
   output logic [7:0] cmd_issued,
   output logic stop_req,
   output logic idle_enter
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] pin0_sync;
      logic [2:0] pin1_sync;
      logic [1:0] pin_lvl;
      tcs_pkg::tcs_mode_t mode;
      logic [7:0] arg0;
      logic [7:0] arg1;
      logic [7:0] cmd;
      logic [7:0] prev;
      logic [7:0] status;
      logic [7:0] tag;
      logic [7:0] tid;
      logic [6:0] bus_addr;
      logic [2:0] conv;
      logic [1:0] quart;
      logic res_load;
      logic cmd_issue;
      logic idle_enter;
      logic [7:0] rdata;
   } tcs_state_t;

   tcs_state_t st_r;
   tcs_state_t st_nxt;
   logic cmd_go;
   logic addr_ok;
   logic hist_cmd;
   logic [1:0] lhs;
   logic [1:0] rhs;

   // Converter field is three bits and the tag holds five converters at most
   if (CONV_COUNT < 1 || CONV_COUNT > 5) begin : g_conv_check
      $error("CONV_COUNT must lie between 1 and 5");
   end

   assign cmd_go = reg_wr && reg_addr == tcs_pkg::OFS_COMMAND_CODE;
   assign hist_cmd = reg_wdata >= tcs_pkg::CMD_HIST_FIRST
      && reg_wdata <= tcs_pkg::CMD_HIST_LAST;
   // Masked pin levels against expected levels, two-bit compare
   assign lhs = {st_r.arg0[1] & st_r.pin_lvl[1], st_r.arg0[0] & st_r.pin_lvl[0]};
   assign rhs = {st_r.arg0[3], st_r.arg0[2]};
   assign addr_ok = lhs == rhs;
   assign res_index = 7'(reg_addr - tcs_pkg::OFS_RESULT_FIRST);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.res_load = 1'b0;
      st_nxt.cmd_issue = 1'b0;
      st_nxt.idle_enter = 1'b0;
      // Pins are asynchronous; a level counts once stages two and three agree
      st_nxt.pin0_sync = {st_r.pin0_sync[1:0], general_pin_zero};
      st_nxt.pin1_sync = {st_r.pin1_sync[1:0], general_pin_one};
      if (st_r.pin0_sync[1] == st_r.pin0_sync[2]) begin
         st_nxt.pin_lvl[0] = st_r.pin0_sync[2];
      end
      if (st_r.pin1_sync[1] == st_r.pin1_sync[2]) begin
         st_nxt.pin_lvl[1] = st_r.pin1_sync[2];
      end
      // Register writes
      if (reg_wr && reg_addr == tcs_pkg::OFS_ARG_ZERO) begin
         st_nxt.arg0 = reg_wdata;
      end else if (reg_wr && reg_addr == tcs_pkg::OFS_ARG_ONE) begin
         st_nxt.arg1 = reg_wdata;
      end
      // Outside map updates from measurement, calibration or serial readout
      if (area_load) begin
         st_nxt.tag = area_tag;
         st_nxt.tid = st_r.tid + 8'h01;
      end
      // Quarter read finished: refresh with the next quarter
      if (st_r.mode == tcs_pkg::TCS_HIST && reg_rd_end) begin
         if (st_r.quart == tcs_pkg::QUART_LAST) begin
            st_nxt.quart = 2'h0;
            st_nxt.conv = (st_r.conv == 3'(CONV_COUNT - 1)) ? 3'h0
               : st_r.conv + 3'h1;
         end else begin
            st_nxt.quart = st_r.quart + 2'h1;
         end
         st_nxt.tag = {tcs_pkg::HIST_TAG_TOP, st_nxt.conv, st_nxt.quart};
         st_nxt.tid = st_r.tid + 8'h01;
         st_nxt.res_load = 1'b1;
      end
      // Stop pending until the running stage reports completion
      if (st_r.mode == tcs_pkg::TCS_STOPPING && stage_done) begin
         st_nxt.mode = tcs_pkg::TCS_IDLE;
         st_nxt.idle_enter = 1'b1;
      end
      // Commands; a histogram command overrides any refresh in the same cycle
      if (cmd_go) begin
         st_nxt.cmd = reg_wdata;
         st_nxt.prev = reg_wdata;
         if (reg_wdata == tcs_pkg::CMD_STOP) begin
            if (st_r.mode != tcs_pkg::TCS_STOPPING) begin
               st_nxt.mode = stage_done ? tcs_pkg::TCS_IDLE : tcs_pkg::TCS_STOPPING;
               st_nxt.idle_enter = stage_done;
            end
         end else if (hist_cmd) begin
            st_nxt.mode = tcs_pkg::TCS_HIST;
            st_nxt.conv = reg_wdata[tcs_pkg::CONV_MSB:tcs_pkg::CONV_LSB];
            st_nxt.quart = reg_wdata[tcs_pkg::QUART_MSB:0];
            st_nxt.tag = reg_wdata;
            st_nxt.tid = st_r.tid + 8'h01;
            st_nxt.res_load = 1'b1;
         end else if (reg_wdata == tcs_pkg::CMD_ADDR_CHANGE) begin
            // Argument bit 0 is ignored; only bits 7:1 form the address
            if (addr_ok) begin
               st_nxt.bus_addr = st_r.arg1[7:1];
               st_nxt.status = tcs_pkg::STATUS_OK;
            end else begin
               st_nxt.status = tcs_pkg::STATUS_ADDR_REFUSED;
            end
         end else begin
            st_nxt.cmd_issue = 1'b1;
            if (st_r.mode == tcs_pkg::TCS_HIST) begin
               st_nxt.mode = tcs_pkg::TCS_IDLE;
            end
         end
      end
      // Read data, captured one cycle after the strobe
      if (reg_rd) begin
         if (reg_addr == tcs_pkg::OFS_ARG_ZERO) begin
            st_nxt.rdata = st_r.arg0;
         end else if (reg_addr == tcs_pkg::OFS_ARG_ONE) begin
            st_nxt.rdata = st_r.arg1;
         end else if (reg_addr == tcs_pkg::OFS_COMMAND_CODE) begin
            st_nxt.rdata = st_r.cmd;
         end else if (reg_addr == tcs_pkg::OFS_LAST_COMMAND_ECHO) begin
            st_nxt.rdata = st_r.prev;
         end else if (reg_addr == tcs_pkg::OFS_FIRMWARE_MINOR_REV) begin
            st_nxt.rdata = FW_MINOR_REV;
         end else if (reg_addr == tcs_pkg::OFS_FIRMWARE_PATCH_REV) begin
            st_nxt.rdata = FW_PATCH_REV;
         end else if (reg_addr == tcs_pkg::OFS_OPERATION_STATUS) begin
            st_nxt.rdata = st_r.status;
         end else if (reg_addr == tcs_pkg::OFS_RESULT_AREA_TAG) begin
            st_nxt.rdata = st_r.tag;
         end else if (reg_addr == tcs_pkg::OFS_MAP_UPDATE_TAG) begin
            st_nxt.rdata = st_r.tid;
         end else if (reg_addr >= tcs_pkg::OFS_RESULT_FIRST
               && reg_addr <= tcs_pkg::OFS_RESULT_LAST) begin
            st_nxt.rdata = res_rdata;
         end else begin
            st_nxt.rdata = tcs_pkg::RST_BYTE;
         end
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '{pin0_sync: tcs_pkg::RST_SYNC, pin1_sync: tcs_pkg::RST_SYNC,
            pin_lvl: 2'h0, mode: tcs_pkg::TCS_IDLE, arg0: tcs_pkg::RST_BYTE,
            arg1: tcs_pkg::RST_BYTE, cmd: tcs_pkg::RST_BYTE, prev: tcs_pkg::RST_BYTE,
            status: tcs_pkg::RST_BYTE, tag: tcs_pkg::RST_BYTE, tid: tcs_pkg::RST_BYTE,
            bus_addr: tcs_pkg::RST_BUS_ADDR, conv: 3'h0, quart: 2'h0, res_load: 1'b0,
            cmd_issue: 1'b0, idle_enter: 1'b0, rdata: tcs_pkg::RST_BYTE};
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;
   assign bus_addr = st_r.bus_addr;
   assign res_conv = st_r.conv;
   assign res_quart = st_r.quart;
   assign res_load = st_r.res_load;
   assign cmd_issue = st_r.cmd_issue;
   assign cmd_issued = st_r.cmd;
   // Continuous measurement must end while stop waits
   assign stop_req = st_r.mode == tcs_pkg::TCS_STOPPING;
   assign idle_enter = st_r.idle_enter;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_addr_apply;
      @(posedge core_clk) disable iff (!rst_n || !clk_en)
      cmd_go && reg_wdata == tcs_pkg::CMD_ADDR_CHANGE && addr_ok
         |=> bus_addr == $past(st_r.arg1[7:1]);
   endproperty
   a_addr_apply: assert property (p_addr_apply) else $error("address not applied");

   property p_addr_keep;
      @(posedge core_clk) disable iff (!rst_n || !clk_en)
      cmd_go && reg_wdata == tcs_pkg::CMD_ADDR_CHANGE && !addr_ok
         |=> $stable(bus_addr) && st_r.status >= tcs_pkg::STATUS_ERR_FIRST;
   endproperty
   a_addr_keep: assert property (p_addr_keep) else $error("refused change altered address");

   property p_hist_sel;
      @(posedge core_clk) disable iff (!rst_n || !clk_en)
      cmd_go && hist_cmd |=> res_load && res_conv == $past(reg_wdata[4:2])
         && res_quart == $past(reg_wdata[1:0]);
   endproperty
   a_hist_sel: assert property (p_hist_sel) else $error("quarter select wrong");

   property p_load_tag;
      @(posedge core_clk) disable iff (!rst_n || !clk_en)
      res_load |-> st_r.tag == {tcs_pkg::HIST_TAG_TOP, res_conv, res_quart};
   endproperty
   a_load_tag: assert property (p_load_tag) else $error("tag does not match quarter");

   property p_next_conv;
      @(posedge core_clk) disable iff (!rst_n || !clk_en)
      st_r.mode == tcs_pkg::TCS_HIST && reg_rd_end && !cmd_go && res_quart == 2'h3
         && res_conv < 3'(CONV_COUNT - 1) |=> res_conv == $past(res_conv) + 3'h1
         && res_quart == 2'h0 && res_load;
   endproperty
   a_next_conv: assert property (p_next_conv) else $error("converter did not advance");

   property p_stop_hold;
      @(posedge core_clk) disable iff (!rst_n || !clk_en)
      stop_req && !stage_done |=> stop_req && !idle_enter;
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop cut the stage short");

   property p_stop_end;
      @(posedge core_clk) disable iff (!rst_n || !clk_en)
      stop_req && stage_done |=> !stop_req && idle_enter ##1 !idle_enter;
   endproperty
   a_stop_end: assert property (p_stop_end) else $error("idle not entered after stop");

   property p_echo;
      @(posedge core_clk) disable iff (!rst_n || !clk_en)
      cmd_go |=> st_r.prev == $past(reg_wdata);
   endproperty
   a_echo: assert property (p_echo) else $error("echo not updated");

   property p_tid;
      @(posedge core_clk) disable iff (!rst_n || !clk_en)
      res_load |-> st_r.tid != $past(st_r.tid);
   endproperty
   a_tid: assert property (p_tid) else $error("transaction id unchanged");

   c_addr_ok: cover property (@(posedge core_clk) disable iff (!rst_n)
      cmd_go && reg_wdata == tcs_pkg::CMD_ADDR_CHANGE && addr_ok);
   c_wrap: cover property (@(posedge core_clk) disable iff (!rst_n)
      res_load && res_conv == 3'h0 && res_quart == 2'h0 && $past(res_conv) != 3'h0);
   c_stop_wait: cover property (@(posedge core_clk) disable iff (!rst_n)
      stop_req ##1 stop_req ##1 idle_enter);

   property p_area_tag;
      @(posedge core_clk) disable iff (!rst_n || !clk_en)
      area_load && !cmd_go && !(st_r.mode == tcs_pkg::TCS_HIST && reg_rd_end)
         |=> st_r.tag == $past(area_tag) && st_r.tid != $past(st_r.tid);
   endproperty
   a_area_tag: assert property (p_area_tag) else $error("content tag not refreshed");

   c_next_conv: cover property (@(posedge core_clk) disable iff (!rst_n)
      res_load && res_quart == 2'h0 && res_conv != 3'h0);
endmodule

// ### tcs_far_model.sv
// Far-side model: result storage and processing core behind the map
`timescale 1ns/1ps
module tcs_far_model (
   input wire logic core_clk,
   input wire logic [6:0] res_index,
   output logic [7:0] res_rdata,
   output logic stage_done,
   output logic area_load,
   output logic [7:0] area_tag
);
   logic busy_r = 1'b0;
   // ----------------------------------------
   // Storage and stage state
   // ----------------------------------------
   // Byte differs per index, so a wrong index shows
   assign res_rdata = {1'b0, res_index} ^ 8'h5a;
   // Low while a stage still runs; a stop must wait for it
   assign stage_done = !busy_r;
   initial begin
      area_load = 1'b0;
      area_tag = 8'h00;
   end
   task automatic set_busy(input logic b);
      busy_r = b;
   endtask
   // One-cycle refresh pulse with its tag; tag inverted afterwards
   task automatic refresh(input logic [7:0] tag);
      @(posedge core_clk);
      #1 area_load = 1'b1;
      area_tag = tag;
      @(posedge core_clk);
      #1 area_load = 1'b0;
      area_tag = ~tag;
   endtask
endmodule

// ### tb_tcs_command_status_map.sv
// Self-checking testbench of the command and status map
`timescale 1ns/1ps
module tb_tcs_command_status_map;
   localparam logic [7:0] A_CMD = tcs_pkg::OFS_COMMAND_CODE;
   localparam logic [7:0] A_TAG = tcs_pkg::OFS_RESULT_AREA_TAG;
   localparam logic [7:0] A_TID = tcs_pkg::OFS_MAP_UPDATE_TAG;
   localparam logic [7:0] A_ECHO = tcs_pkg::OFS_LAST_COMMAND_ECHO;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic reg_rd_end = 1'b0;
   logic clk_en = 1'b1;
   logic pin0 = 1'b1;
   logic pin1 = 1'b0;
   logic [7:0] reg_rdata, res_rdata, area_tag, cmd_issued, got, tid0, e;
   logic [6:0] res_index, bus_addr, exp_addr;
   logic [2:0] res_conv;
   logic [1:0] res_quart;
   logic res_load, cmd_issue, stop_req, idle_enter, stage_done, area_load, ok;
   logic [7:0] conds [5] = '{8'h00, 8'h01, 8'h05, 8'h0a, 8'h03};
   logic [7:0] tags [3] = '{8'h55, 8'h0a, 8'h47};
   int bad_count = 0;
   int samples_checked = 0;
   int n_load = 0;
   int n_idle = 0;
   int n_cmd = 0;
   int l0, i0;
   tcs_command_status_map uut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rd_end(reg_rd_end), .reg_rdata(reg_rdata), .res_rdata(res_rdata),
      .res_index(res_index), .general_pin_zero(pin0), .general_pin_one(pin1),
      .stage_done(stage_done), .area_load(area_load), .area_tag(area_tag),
      .bus_addr(bus_addr), .res_conv(res_conv), .res_quart(res_quart), .res_load(res_load),
      .cmd_issue(cmd_issue), .cmd_issued(cmd_issued), .stop_req(stop_req),
      .idle_enter(idle_enter));
   tcs_far_model far (.core_clk(core_clk), .res_index(res_index), .res_rdata(res_rdata),
      .stage_done(stage_done), .area_load(area_load), .area_tag(area_tag));
   always #20 core_clk = ~core_clk;
   // ----------------------------------------
   // Pulse counters and timeout
   // ----------------------------------------
   always @(posedge core_clk) begin
      if (res_load) n_load <= n_load + 1;
      if (idle_enter) n_idle <= n_idle + 1;
      if (cmd_issue) n_cmd <= n_cmd + 1;
   end
   initial begin
      repeat (6000) @(posedge core_clk);
      bad_count++;
      print_verdict();
   end
   // ----------------------------------------
   // Access and compare tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1 reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge core_clk);
      #1 reg_wr = 1'b0;
   endtask
   task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      #1 reg_rd = 1'b1;
      reg_addr = a;
      @(posedge core_clk);
      #1 reg_rd = 1'b0;
      got = reg_rdata;
      chk(name, exp, got);
   endtask
   // Read end pulse, then one edge so refreshed state lands
   task automatic rd_end();
      @(posedge core_clk);
      #1 reg_rd_end = 1'b1;
      @(posedge core_clk);
      #1 reg_rd_end = 1'b0;
      @(posedge core_clk);
      #1;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge core_clk);
      #1 rst_n = 1'b1;
      chk("bus_addr", 8'h10, {1'b0, bus_addr});
      rchk("echo", A_ECHO, 8'h00);
      rchk("minor", tcs_pkg::OFS_FIRMWARE_MINOR_REV, 8'h01);
      rchk("status", tcs_pkg::OFS_OPERATION_STATUS, 8'h00);
      rchk("tag", A_TAG, 8'h00);
      rchk("tid", A_TID, 8'h00);
      wr(tcs_pkg::OFS_FIRMWARE_PATCH_REV, 8'ha5);
      rchk("patch", tcs_pkg::OFS_FIRMWARE_PATCH_REV, 8'h02);
      rchk("unmapped", 8'hc0, 8'h00);
      rchk("result", 8'h25, 8'h5f);
      $display("test reset done");
      exp_addr = 7'h10;
      foreach (conds[i]) begin
         wr(tcs_pkg::OFS_ARG_ZERO, conds[i]);
         wr(tcs_pkg::OFS_ARG_ONE, {7'h20 + 7'(i), 1'b0});
         wr(A_CMD, tcs_pkg::CMD_ADDR_CHANGE);
         ok = ({conds[i][1] & pin1, conds[i][0] & pin0} == conds[i][3:2]);
         if (ok) exp_addr = 7'h20 + 7'(i);
         rchk("status", tcs_pkg::OFS_OPERATION_STATUS, ok ? 8'h00 : 8'h10);
         chk("bus_addr", {1'b0, exp_addr}, {1'b0, bus_addr});
         rchk("echo", A_ECHO, 8'h49);
      end
      $display("test address change done");
      rchk("tid", A_TID, 8'h00);
      tid0 = got;
      l0 = n_load;
      // Start on converter three so both the advance and the wrap are seen
      e = 8'h8e;
      wr(A_CMD, e);
      for (int s = 0; s < 8; s++) begin
         if (s > 0) begin
            rd_end();
            e = (e == 8'h93) ? 8'h80 : e + 8'h01;
         end
         chk("conv", {5'h00, e[4:2]}, {5'h00, res_conv});
         chk("quart", {6'h00, e[1:0]}, {6'h00, res_quart});
         rchk("tag", A_TAG, e);
         rchk("tid", A_TID, tid0 + 8'(s + 1));
         chk("loads", 8'(s + 1), 8'(n_load - l0));
      end
      l0 = n_cmd;
      wr(A_CMD, 8'h02);
      rchk("echo", A_ECHO, 8'h02);
      chk("issued", 8'h02, cmd_issued);
      chk("issues", 8'h01, 8'(n_cmd - l0));
      rd_end();
      rchk("tag", A_TAG, e);
      $display("test histogram done");
      i0 = n_idle;
      far.set_busy(1'b1);
      wr(A_CMD, tcs_pkg::CMD_STOP);
      repeat (5) @(posedge core_clk);
      #1 chk("stop_req", 8'h01, {7'h00, stop_req});
      chk("idles", 8'h00, 8'(n_idle - i0));
      far.set_busy(1'b0);
      for (int k = 0; k < 10 && n_idle == i0; k++) @(posedge core_clk);
      #1 chk("idles", 8'h01, 8'(n_idle - i0));
      chk("stop_req", 8'h00, {7'h00, stop_req});
      rchk("echo", A_ECHO, 8'hff);
      wr(A_CMD, tcs_pkg::CMD_STOP);
      repeat (3) @(posedge core_clk);
      #1 chk("idles", 8'h02, 8'(n_idle - i0));
      $display("test stop done");
      // Eight quarter loads moved the ID on since tid0 was taken
      tid0 = tid0 + 8'h08;
      foreach (tags[i]) begin
         rchk("tid", A_TID, tid0);
         far.refresh(tags[i]);
         tid0 = tid0 + 8'h01;
         rchk("tag", A_TAG, tags[i]);
         rchk("tid", A_TID, tid0);
      end
      $display("test refresh done");
      clk_en = 1'b0;
      wr(A_CMD, 8'h03);
      clk_en = 1'b1;
      rchk("echo", A_ECHO, 8'hff);
      chk("issues", 8'h01, 8'(n_cmd - l0));
      rst_n = 1'b0;
      @(posedge core_clk);
      #1 rst_n = 1'b1;
      chk("bus_addr", 8'h10, {1'b0, bus_addr});
      rchk("tid", A_TID, 8'h00);
      $display("test freeze and reset done");
      print_verdict();
   end
endmodule
